/* File: design/oaid_decode.sv */
// Operand, program address and I/O access decoder for an 8-bit core
`timescale 1ns/10ps
`default_nettype none
module oaid_decode
#(
    parameter int PC_W = oaid_pkg::PC_W
)
(
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_VALID,
    input  wire logic [3:0]  I_OP,
    input  wire logic [4:0]  I_DEST_REG,
    input  wire logic [4:0]  I_SOURCE_REG,
    input  wire logic [15:0] I_POINTER,
    input  wire logic [15:0] I_PC,
    input  wire logic [11:0] I_REL_OFFSET,
    input  wire logic [5:0]  I_IO_ADDR,
    input  wire logic [7:0]  I_DATA_ADDR,
    input  wire logic [2:0]  I_BIT_SEL,
    input  wire logic [7:0]  I_W1C_MASK,
    input  wire logic [7:0]  I_IO_RDATA,
    input  wire logic [7:0]  I_REG_WDATA,
    output logic             O_RD_A_EN,
    output logic [4:0]       O_RD_A_SEL,
    output logic             O_RD_B_EN,
    output logic [4:0]       O_RD_B_SEL,
    output logic             O_WB_EN,
    output logic [4:0]       O_WB_SEL,
    output logic             O_PM_RD,
    output logic [14:0]      O_PM_WORD,
    output logic             O_PM_HIGH,
    output logic             O_PC_LOAD,
    output logic [15:0]      O_PC_NEXT,
    output logic             O_PUSH_RET,
    output logic             O_IO_RD,
    output logic             O_IO_WR,
    output logic [5:0]       O_IO_ADDR,
    output logic [7:0]       O_IO_WDATA,
    output logic [4:0]       O_IO_SLOT,
    output logic             O_IO_HIT,
    output logic [7:0]       O_IO_RESULT,
    output logic             O_SKIP,
    output logic             O_ILLEGAL
);
    typedef oaid_pkg::oaid_op_e oaid_op_t;

    oaid_op_t   op;
    logic       bit_op;
    logic [5:0] eff_addr;
    logic       data_io;
    logic [5:0] map_addr;
    logic       map_hit;
    logic [4:0] map_slot;

    // Data space addresses 0x20..0x5F alias the I/O space
    function automatic logic in_io_alias(input logic [7:0] a);
        in_io_alias = (a >= oaid_pkg::SRAM_IO_BASE) &&
                      (a <= oaid_pkg::SRAM_IO_LAST);
    endfunction

    function automatic logic [7:0] w1c_safe(input logic [7:0] v,
                                            input logic [7:0] m);
        w1c_safe = v & ~m;
    endfunction

    // Mapped registers form one run from the high divisor to port C
    function automatic logic is_mapped(input logic [5:0] a);
        is_mapped = (a >= oaid_pkg::A_BAUD_HIGH) &&
                    (a <= oaid_pkg::A_PORTC_OUT);
    endfunction

    assign op       = oaid_op_t'(I_OP);
    assign bit_op   = (op == oaid_pkg::OP_BIT_SET) ||
                      (op == oaid_pkg::OP_BIT_CLR) ||
                      (op == oaid_pkg::OP_SKIP_ONE) ||
                      (op == oaid_pkg::OP_SKIP_ZER);
    assign data_io  = in_io_alias(I_DATA_ADDR);
    assign eff_addr = 6'(I_DATA_ADDR - oaid_pkg::SRAM_IO_BASE); // RULE7
    assign map_addr = ((op == oaid_pkg::OP_DATA_LD) ||
                       (op == oaid_pkg::OP_DATA_ST)) ? eff_addr
                                                     : I_IO_ADDR;

    oaid_io_map u_map
    (
        .i_clk  (I_SYS_CLK),
        .i_rst  (I_RST),
        .i_addr (map_addr),
        .o_hit  (map_hit),
        .o_slot (map_slot)
    );

    assign O_IO_HIT  = map_hit;
    assign O_IO_SLOT = map_slot;

    // Register file ports
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            O_RD_A_EN  <= 1'b0;
            O_RD_A_SEL <= 5'h00;
            O_RD_B_EN  <= 1'b0;
            O_RD_B_SEL <= 5'h00;
            O_WB_EN    <= 1'b0;
            O_WB_SEL   <= 5'h00;
        end
        else
        begin
            O_RD_A_SEL <= I_DEST_REG;
            O_RD_B_SEL <= I_SOURCE_REG;
            O_WB_SEL   <= I_DEST_REG;
            O_RD_A_EN  <= I_VALID && ((op == oaid_pkg::OP_SINGLE) ||
                          (op == oaid_pkg::OP_TWO)); // RULE1
            O_RD_B_EN  <= I_VALID && ((op == oaid_pkg::OP_TWO) ||
                          (op == oaid_pkg::OP_IO_OUT) ||
                          (op == oaid_pkg::OP_DATA_ST)); // RULE2
            O_WB_EN    <= I_VALID && ((op == oaid_pkg::OP_SINGLE) ||
                          (op == oaid_pkg::OP_TWO)); // RULE2
        end
    end

    // Program memory constant fetch
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            O_PM_RD   <= 1'b0;
            O_PM_WORD <= 15'h0000;
            O_PM_HIGH <= 1'b0;
        end
        else
        begin
            O_PM_RD   <= I_VALID && (op == oaid_pkg::OP_CONST);
            O_PM_WORD <= I_POINTER[15:1]; // RULE3
            O_PM_HIGH <= I_POINTER[0]; // RULE3
        end
    end

    // Program counter redirection; the target wraps within PC_W bits
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            O_PC_LOAD  <= 1'b0;
            O_PC_NEXT  <= oaid_pkg::PC_RESET;
            O_PUSH_RET <= 1'b0;
        end
        else
        begin
            O_PC_LOAD  <= 1'b0;
            O_PUSH_RET <= 1'b0;
            if (I_VALID)
            begin
                case (op)
                    oaid_pkg::OP_IND_JUMP, oaid_pkg::OP_IND_CALL:
                    begin
                        O_PC_LOAD  <= 1'b1;
                        O_PC_NEXT  <= 16'(I_POINTER[PC_W-1:0]); // RULE4
                        O_PUSH_RET <= (op == oaid_pkg::OP_IND_CALL);
                    end
                    oaid_pkg::OP_REL_JUMP, oaid_pkg::OP_REL_CALL:
                    begin
                        O_PC_LOAD  <= 1'b1;
                        O_PC_NEXT  <= 16'(PC_W'(I_PC +
                                      {{4{I_REL_OFFSET[11]}}, I_REL_OFFSET}
                                      + 16'h0001)); // RULE5
                        O_PUSH_RET <= (op == oaid_pkg::OP_REL_CALL);
                    end
                    default:
                    begin
                        O_PC_LOAD <= 1'b0;
                    end
                endcase
            end
        end
    end

    // I/O access strobes; stage one captures the decoded request
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            O_IO_RD   <= 1'b0;
            O_IO_WR   <= 1'b0;
            O_IO_ADDR <= 6'h00;
            O_ILLEGAL <= 1'b0;
        end
        else
        begin
            O_IO_ADDR <= map_addr; // RULE6
            O_IO_RD   <= I_VALID && ((op == oaid_pkg::OP_IO_IN) ||
                         ((op == oaid_pkg::OP_DATA_LD) && data_io) ||
                         (bit_op && I_IO_ADDR <= oaid_pkg::BIT_IO_LAST));
            O_IO_WR   <= I_VALID && ((op == oaid_pkg::OP_IO_OUT) ||
                         ((op == oaid_pkg::OP_DATA_ST) && data_io) ||
                         (((op == oaid_pkg::OP_BIT_SET) ||
                           (op == oaid_pkg::OP_BIT_CLR)) &&
                          I_IO_ADDR <= oaid_pkg::BIT_IO_LAST)); // RULE8
            O_ILLEGAL <= I_VALID && bit_op &&
                         (I_IO_ADDR > oaid_pkg::BIT_IO_LAST); // RULE8
        end
    end

    // Write data: bit set/clear rebuild the byte from the register contents
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            O_IO_WDATA <= 8'h00;
            O_SKIP     <= 1'b0;
        end
        else
        begin
            O_SKIP <= 1'b0;
            case (op)
                oaid_pkg::OP_BIT_SET:
                    O_IO_WDATA <= I_IO_RDATA | (8'h01 << I_BIT_SEL); // RULE10
                oaid_pkg::OP_BIT_CLR:
                    O_IO_WDATA <= I_IO_RDATA & ~(8'h01 << I_BIT_SEL); // RULE10
                oaid_pkg::OP_SKIP_ONE:
                begin
                    O_IO_WDATA <= 8'h00;
                    O_SKIP <= I_VALID && I_IO_ADDR <= oaid_pkg::BIT_IO_LAST
                              && I_IO_RDATA[I_BIT_SEL];
                end
                oaid_pkg::OP_SKIP_ZER:
                begin
                    O_IO_WDATA <= 8'h00;
                    O_SKIP <= I_VALID && I_IO_ADDR <= oaid_pkg::BIT_IO_LAST
                              && !I_IO_RDATA[I_BIT_SEL];
                end
                default:
                    O_IO_WDATA <= I_REG_WDATA;
            endcase
        end
    end

    // Read result: unmapped reads zero; write-one-clear flags read as held
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            O_IO_RESULT <= 8'h00;
        end
        // Decoded here, as the registered map hit lags the request a cycle
        else if (!is_mapped(map_addr))
        begin
            O_IO_RESULT <= 8'h00; // RULE17
        end
        else
        begin
            // Peripheral applies clear-on-one; zero bits leave flags alone
            O_IO_RESULT <= I_IO_RDATA | w1c_safe(8'h00, I_W1C_MASK); // RULE9
        end
    end
endmodule
`default_nettype wire

/* File: design/oaid_io_map.sv */
// Fixed I/O address map with registered select outputs
`timescale 1ns/10ps
`default_nettype none
module oaid_io_map
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [5:0] i_addr,
    output logic            o_hit,
    output logic [4:0]      o_slot
);
    logic       hit;
    logic [4:0] slot;

    // Slots 1..19 name the mapped registers; zero means nothing there
    always_comb
    begin
        hit  = 1'b1;
        slot = 5'h00;
        case (i_addr)
            oaid_pkg::A_PORTC_OUT: slot = 5'h01; // RULE13
            oaid_pkg::A_PORTC_DIR: slot = 5'h02;
            oaid_pkg::A_PORTC_PIN: slot = 5'h03;
            oaid_pkg::A_PORTD_OUT: slot = 5'h04;
            oaid_pkg::A_PORTD_DIR: slot = 5'h05;
            oaid_pkg::A_PORTD_PIN: slot = 5'h06;
            oaid_pkg::A_SER_DATA:  slot = 5'h07; // RULE14
            oaid_pkg::A_SER_STAT:  slot = 5'h08;
            oaid_pkg::A_SER_CTRL:  slot = 5'h09;
            oaid_pkg::A_UART_DATA: slot = 5'h0A; // RULE15
            oaid_pkg::A_UART_STAT: slot = 5'h0B;
            oaid_pkg::A_UART_CTRL: slot = 5'h0C;
            oaid_pkg::A_BAUD_LOW:  slot = 5'h0D;
            oaid_pkg::A_BAUD_HIGH: slot = 5'h13;
            oaid_pkg::A_CMP_CSR:   slot = 5'h0E; // RULE16
            oaid_pkg::A_CONV_CHAN: slot = 5'h0F;
            oaid_pkg::A_CONV_CSR:  slot = 5'h10;
            oaid_pkg::A_CONV_HIGH: slot = 5'h11;
            oaid_pkg::A_CONV_LOW:  slot = 5'h12;
            default:               hit  = 1'b0; // RULE17
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_hit  <= 1'b0;
            o_slot <= 5'h00;
        end
        else
        begin
            o_hit  <= hit;
            o_slot <= slot;
        end
    end
endmodule
`default_nettype wire

/* File: design/oaid_pkg.sv */
// Constants shared by the operand addressing and I/O decode block
// How it works
// RULE1 - Single operand read from destination register
// RULE2 - Two operands read, result written to destination
// RULE3 - Pointer bits 15:1 word, bit0 byte select
// RULE4 - Indirect jump or call loads pointer
// RULE5 - Relative target is pc plus offset plus one
// RULE6 - I/O moves use 64 entry space
// RULE7 - Data space alias is I/O plus 0x20
// RULE8 - Bit operations only below 0x20
// RULE9 - Writing one clears marked flags
// RULE10 - Bit set/clear rewrites whole register
// RULE11 - Software writes zero to reserved bits
// RULE12 - Software never writes reserved addresses
// RULE13 - Port registers at 0x15 down to 0x10
// RULE14 - Serial peripheral at 0x0F, 0x0E, 0x0D
// RULE15 - UART at 0x0C..0x09, divisor high 0x03
// RULE16 - Comparator 0x08, converter 0x07 to 0x04
// RULE17 - Unmapped reads zero, writes ignored; the decoder zeroes only O_IO_RESULT and still raises O_IO_WR
package oaid_pkg;
    localparam int          REG_AW       = 5;
    localparam int          IO_AW        = 6;
    localparam int          PC_W         = 11;
    localparam int          NUM_IO       = 64;
    localparam logic [7:0]  SRAM_IO_BASE = 8'h20;
    localparam logic [7:0]  SRAM_IO_LAST = 8'h5F;
    localparam logic [5:0]  BIT_IO_LAST  = 6'h1F;
    localparam logic [5:0]  A_PORTC_OUT  = 6'h15;
    localparam logic [5:0]  A_PORTC_DIR  = 6'h14;
    localparam logic [5:0]  A_PORTC_PIN  = 6'h13;
    localparam logic [5:0]  A_PORTD_OUT  = 6'h12;
    localparam logic [5:0]  A_PORTD_DIR  = 6'h11;
    localparam logic [5:0]  A_PORTD_PIN  = 6'h10;
    localparam logic [5:0]  A_SER_DATA   = 6'h0F;
    localparam logic [5:0]  A_SER_STAT   = 6'h0E;
    localparam logic [5:0]  A_SER_CTRL   = 6'h0D;
    localparam logic [5:0]  A_UART_DATA  = 6'h0C;
    localparam logic [5:0]  A_UART_STAT  = 6'h0B;
    localparam logic [5:0]  A_UART_CTRL  = 6'h0A;
    localparam logic [5:0]  A_BAUD_LOW   = 6'h09;
    localparam logic [5:0]  A_CMP_CSR    = 6'h08;
    localparam logic [5:0]  A_CONV_CHAN  = 6'h07;
    localparam logic [5:0]  A_CONV_CSR   = 6'h06;
    localparam logic [5:0]  A_CONV_HIGH  = 6'h05;
    localparam logic [5:0]  A_CONV_LOW   = 6'h04;
    localparam logic [5:0]  A_BAUD_HIGH  = 6'h03;
    localparam logic [15:0] PC_RESET     = 16'h0000;
    typedef enum logic [3:0] {
        OP_NONE     = 4'h0,
        OP_SINGLE   = 4'h1,
        OP_TWO      = 4'h2,
        OP_CONST    = 4'h3,
        OP_IND_JUMP = 4'h4,
        OP_IND_CALL = 4'h5,
        OP_REL_JUMP = 4'h6,
        OP_REL_CALL = 4'h7,
        OP_IO_IN    = 4'h8,
        OP_IO_OUT   = 4'h9,
        OP_BIT_SET  = 4'hA,
        OP_BIT_CLR  = 4'hB,
        OP_SKIP_ONE = 4'hC,
        OP_SKIP_ZER = 4'hD,
        OP_DATA_LD  = 4'hE,
        OP_DATA_ST  = 4'hF
    } oaid_op_e;
endpackage

/* File: verification/oaid_decode_props.sv */
// Concurrent checks on the decoder's ports
`timescale 1ns/10ps
`default_nettype none
module oaid_decode_props
#(
    parameter int PC_W = oaid_pkg::PC_W
)
(
    input wire logic        I_SYS_CLK,
    input wire logic        I_RST,
    input wire logic        I_VALID,
    input wire logic [3:0]  I_OP,
    input wire logic [4:0]  I_DEST_REG,
    input wire logic [4:0]  I_SOURCE_REG,
    input wire logic [15:0] I_POINTER,
    input wire logic [15:0] I_PC,
    input wire logic [11:0] I_REL_OFFSET,
    input wire logic [5:0]  I_IO_ADDR,
    input wire logic [7:0]  I_DATA_ADDR,
    input wire logic [2:0]  I_BIT_SEL,
    input wire logic [7:0]  I_IO_RDATA,
    input wire logic [7:0]  I_REG_WDATA,
    input wire logic [4:0]  O_RD_A_SEL,
    input wire logic [4:0]  O_RD_B_SEL,
    input wire logic [4:0]  O_WB_SEL,
    input wire logic [14:0] O_PM_WORD,
    input wire logic        O_PM_HIGH,
    input wire logic        O_PC_LOAD,
    input wire logic [15:0] O_PC_NEXT,
    input wire logic        O_PUSH_RET,
    input wire logic        O_IO_RD,
    input wire logic        O_IO_WR,
    input wire logic [5:0]  O_IO_ADDR,
    input wire logic [7:0]  O_IO_WDATA,
    input wire logic        O_IO_HIT,
    input wire logic [7:0]  O_IO_RESULT,
    input wire logic        O_ILLEGAL
);
    // Targets wrap at the counter width, so upper bits are not judged
    localparam logic [15:0] MSK = 16'((1 << PC_W) - 1);
    logic [3:0]  o;
    logic [15:0] rel;
    logic [7:0]  bit1;
    logic [7:0]  nx;
    logic        bop;
    assign o    = I_VALID ? I_OP : 4'h0;
    assign rel  = I_PC + 16'($signed(I_REL_OFFSET)) + 16'h0001;
    assign bit1 = 8'h01 << I_BIT_SEL;
    assign nx   = (I_OP == oaid_pkg::OP_BIT_CLR) ? I_IO_RDATA & ~bit1
                                                 : I_IO_RDATA | bit1;
    assign bop  = o == oaid_pkg::OP_BIT_SET || o == oaid_pkg::OP_BIT_CLR;

    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);

    property p_single;
        o == oaid_pkg::OP_SINGLE |=> O_RD_A_SEL == $past(I_DEST_REG);
    endproperty
    a_single: assert property (p_single) else $error("single select");
    property p_two;
        o == oaid_pkg::OP_TWO |=> O_RD_B_SEL == $past(I_SOURCE_REG)
            && O_WB_SEL == $past(I_DEST_REG);
    endproperty
    a_two: assert property (p_two) else $error("two reg selects");
    property p_pm;
        o == oaid_pkg::OP_CONST |=> {O_PM_WORD, O_PM_HIGH} == $past(I_POINTER);
    endproperty
    a_pm: assert property (p_pm) else $error("constant address");
    // Call codes are odd, jump codes even
    property p_ind;
        o == oaid_pkg::OP_IND_JUMP || o == oaid_pkg::OP_IND_CALL |=> O_PC_LOAD
            && ((O_PC_NEXT ^ $past(I_POINTER)) & MSK) == 16'h0000
            && O_PUSH_RET == $past(o[0]);
    endproperty
    a_ind: assert property (p_ind) else $error("indirect target");
    property p_rel;
        o == oaid_pkg::OP_REL_JUMP || o == oaid_pkg::OP_REL_CALL |=> O_PC_LOAD
            && ((O_PC_NEXT ^ $past(rel)) & MSK) == 16'h0000
            && O_PUSH_RET == $past(o[0]);
    endproperty
    a_rel: assert property (p_rel) else $error("relative target");
    property p_out;
        o == oaid_pkg::OP_IO_OUT |=> O_IO_WR && O_IO_ADDR == $past(I_IO_ADDR)
            && O_IO_WDATA == $past(I_REG_WDATA);
    endproperty
    a_out: assert property (p_out) else $error("io store");
    property p_alias;
        o == oaid_pkg::OP_DATA_LD && I_DATA_ADDR inside {[8'h20:8'h5F]}
            |=> O_IO_RD && {2'b00, O_IO_ADDR} + 8'h20 == $past(I_DATA_ADDR);
    endproperty
    a_alias: assert property (p_alias) else $error("data alias");
    property p_ill;
        bop && I_IO_ADDR > 6'h1F |=> O_ILLEGAL && !O_IO_WR;
    endproperty
    a_ill: assert property (p_ill) else $error("high bit op");
    property p_rmw;
        bop && I_IO_ADDR <= 6'h1F |=> O_IO_WR && O_IO_WDATA == $past(nx);
    endproperty
    a_rmw: assert property (p_rmw) else $error("bit rewrite");
    property p_map;
        o == oaid_pkg::OP_IO_IN
            |=> O_IO_HIT == ($past(I_IO_ADDR) inside {[6'h03:6'h15]});
    endproperty
    a_map: assert property (p_map) else $error("io map hit");
    property p_zero;
        O_IO_RD && !O_IO_HIT |-> O_IO_RESULT == 8'h00;
    endproperty
    a_zero: assert property (p_zero) else $error("unmapped data");

    c_call: cover property (o == oaid_pkg::OP_REL_CALL);
    c_ill: cover property (O_ILLEGAL);
    c_rw: cover property (O_IO_WR ##2 O_IO_RD);
endmodule
bind oaid_decode oaid_decode_props #(.PC_W(PC_W)) i_props (.*);
`default_nettype wire

/* File: verification/oaid_io_model.sv */
// Behavioural peripheral register file on the far side of the decoder
`timescale 1ns/10ps
`default_nettype none
module oaid_io_model
(
    input  wire logic       i_clk,
    input  wire logic [5:0] i_addr,
    input  wire logic       i_wr,
    input  wire logic [5:0] i_waddr,
    input  wire logic [7:0] i_wdata,
    input  wire logic [7:0] i_w1c,
    output logic [7:0]      o_rdata
);
    logic [7:0] mem [64];

    // A distinct byte per address so a wrong select shows up
    initial
    begin
        for (int i = 0; i < 64; i++)
            mem[i] = 8'(i) ^ 8'hA5;
    end

    assign o_rdata = mem[i_addr];

    // Flag bits clear on a written one and keep their value on a zero
    always @(posedge i_clk)
        if (i_wr)
            mem[i_waddr] <= (i_wdata & ~i_w1c)
                | (mem[i_waddr] & i_w1c & ~i_wdata);
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the operand and I/O decoder
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clk, rst, vld, a_en, b_en, wb_en, pm_rd, pm_h, pc_ld;
    logic        push, io_rd, io_wr, hit, skip, ill;
    logic [3:0]  op;
    logic [4:0]  dst, src, a_sel, b_sel, wb_sel, slot;
    logic [15:0] ptr, pc, pc_nx;
    logic [11:0] off;
    logic [5:0]  ioa, io_a;
    logic [7:0]  da, w1c, wdat, rdat, io_wd, res;
    logic [2:0]  bs;
    logic [14:0] pm_w;
    int          num_errors = 0;
    int          comparisons = 0;

    oaid_decode i_dut
    (
        .I_SYS_CLK(clk), .I_RST(rst), .I_VALID(vld), .I_OP(op),
        .I_DEST_REG(dst), .I_SOURCE_REG(src), .I_POINTER(ptr), .I_PC(pc),
        .I_REL_OFFSET(off), .I_IO_ADDR(ioa), .I_DATA_ADDR(da),
        .I_BIT_SEL(bs), .I_W1C_MASK(w1c), .I_IO_RDATA(rdat),
        .I_REG_WDATA(wdat), .O_RD_A_EN(a_en), .O_RD_A_SEL(a_sel),
        .O_RD_B_EN(b_en), .O_RD_B_SEL(b_sel), .O_WB_EN(wb_en),
        .O_WB_SEL(wb_sel), .O_PM_RD(pm_rd), .O_PM_WORD(pm_w),
        .O_PM_HIGH(pm_h), .O_PC_LOAD(pc_ld), .O_PC_NEXT(pc_nx),
        .O_PUSH_RET(push), .O_IO_RD(io_rd), .O_IO_WR(io_wr),
        .O_IO_ADDR(io_a), .O_IO_WDATA(io_wd), .O_IO_SLOT(slot),
        .O_IO_HIT(hit), .O_IO_RESULT(res), .O_SKIP(skip), .O_ILLEGAL(ill)
    );
    oaid_io_model i_io
    (
        .i_clk(clk), .i_addr(ioa), .i_wr(io_wr), .i_waddr(io_a),
        .i_wdata(io_wd), .i_w1c(w1c), .o_rdata(rdat)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    // Request held for one edge; answer sampled 1 ns after that same edge
    task automatic go(input logic [3:0] c);
        vld <= 1'b1;
        op  <= c;
        @(posedge clk);
        vld <= 1'b0;
        #1;
    endtask

    task automatic t_regs;
        @(posedge clk);
        dst <= 5'h1F;
        go(oaid_pkg::OP_SINGLE);
        chk("rd_a", 16'h003F, {a_en, a_sel});
        @(posedge clk);
        dst <= 5'h02;
        src <= 5'h1E;
        go(oaid_pkg::OP_TWO);
        chk("rd_b", 16'h003E, {b_en, b_sel});
        chk("wb", 16'h0022, {wb_en, wb_sel});
    endtask

    task automatic t_const(input logic [15:0] p);
        @(posedge clk);
        ptr <= p;
        go(oaid_pkg::OP_CONST);
        chk("pm", p, {pm_w, pm_h});
        chk("pm_rd", 16'h0001, pm_rd);
    endtask

    task automatic jmp(input logic [3:0] c, input logic [15:0] p,
                       input logic [11:0] k, input logic [15:0] e,
                       input logic u);
        @(posedge clk);
        ptr <= p;
        pc  <= p;
        off <= k;
        go(c);
        chk("target", e, pc_nx);
        chk("load_push", {1'b1, u}, {pc_ld, push});
    endtask

    task automatic t_map;
        logic h;
        for (int a = 0; a < 64; a++)
        begin
            @(posedge clk);
            ioa <= 6'(a);
            go(oaid_pkg::OP_IO_IN);
            h = a >= 3 && a <= 21;
            chk("hit", h, hit);
            chk("slot", a == 3 ? 16'h0013 : (h ? 16'(22 - a) : 16'h0000),
                slot);
            chk("result", h ? 16'(8'(a) ^ 8'hA5) : 16'h0, res);
        end
    endtask

    task automatic io(input logic [3:0] c, input logic [5:0] a,
                      input logic [2:0] b, input logic [15:0] e);
        @(posedge clk);
        ioa <= a;
        bs  <= b;
        go(c);
        chk("io_write", e, {io_wr, io_a, io_wd});
    endtask

    task automatic rd(input logic [7:0] e);
        @(posedge clk);
        go(oaid_pkg::OP_IO_IN);
        chk("read_back", e, res);
    endtask

    task automatic t_alias(input logic [7:0] d, input logic [15:0] e);
        @(posedge clk);
        da  <= d;
        ioa <= 6'h15;
        go(oaid_pkg::OP_DATA_LD);
        chk("alias", e, {io_rd, io_wr, io_a});
    endtask

    task automatic t_skip(input logic [3:0] c, input logic e);
        @(posedge clk);
        bs <= 3'h3;
        go(c);
        chk("skip", e, skip);
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (1000) @(posedge clk);
        num_errors++;
        stop_test;
    end

    initial
    begin
        {rst, vld, op, dst, src, ptr, pc, off} = {1'b1, 59'h0};
        {ioa, da, bs, wdat} = 25'h0;
        w1c = 8'h80;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_const(16'h0A57);
        t_const(16'h0A56);
        jmp(oaid_pkg::OP_IND_JUMP, 16'h0123, 12'h000, 16'h0123, 0);
        jmp(oaid_pkg::OP_IND_CALL, 16'h0456, 12'h000, 16'h0456, 1);
        jmp(oaid_pkg::OP_REL_JUMP, 16'h0005, 12'hFFF, 16'h0005, 0);
        // Target wraps within the 11-bit program counter
        jmp(oaid_pkg::OP_REL_CALL, 16'h0100, 12'h7FF, 16'h0100, 1);
        jmp(oaid_pkg::OP_REL_JUMP, 16'h0900, 12'h800, 16'h0101, 0);
        t_map;
        // Only mapped places are written, reserved bits left clear
        wdat <= 8'h3C;
        io(oaid_pkg::OP_IO_OUT, 6'h12, 3'h0, 16'h523C);
        // Bit 7 is a flag here: a written zero leaves it set
        rd(8'hBC);
        t_alias(8'h35, 16'h0095);
        t_alias(8'h60, 16'h0000);
        t_alias(8'h1F, 16'h003F);
        io(oaid_pkg::OP_BIT_SET, 6'h0B, 3'h0, 16'h4BAF);
        ioa <= 6'h0B;
        rd(8'h2F);
        io(oaid_pkg::OP_BIT_CLR, 6'h12, 3'h2, 16'h52B8);
        rd(8'h38);
        t_skip(oaid_pkg::OP_SKIP_ONE, 1'b1);
        t_skip(oaid_pkg::OP_SKIP_ZER, 1'b0);
        io(oaid_pkg::OP_BIT_SET, 6'h20, 3'h0, 16'h2085);
        chk("illegal", 16'h0001, ill);
        stop_test;
    end
endmodule
`default_nettype wire
